// *** common/mie_pkg.sv ***
package mie_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_TABLE_HIGH_POINTER = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_PC = 8'h10;
    localparam logic [7:0] OFF_SP = 8'h14;
    localparam logic [7:0] OFF_WDT = 8'h18;
    localparam logic [7:0] OFF_PRESC = 8'h1C;
    localparam logic [7:0] OFF_FADDR = 8'h20;
    localparam logic [7:0] OFF_FDATA = 8'h24;
    localparam logic [7:0] OFF_STKTOP = 8'h28;
    // Instruction word fields
    localparam int unsigned OP_LSB = 0;
    localparam int unsigned OP_W = 3;
    localparam int unsigned FA_LSB = 3;
    localparam int unsigned FA_W = 6;
    localparam int unsigned BIT_LSB = 9;
    localparam int unsigned BIT_W = 3;
    localparam int unsigned DEST_POS = 12;
    localparam int unsigned INSTR_W = 13;
    localparam int unsigned FILE_DEPTH = 64;
    localparam int unsigned PC_W = 10;
    // Status register bits
    localparam int unsigned ST_Z = 0;
    localparam int unsigned ST_PD_N = 1;
    localparam int unsigned ST_TO_N = 2;
    localparam int unsigned ST_PRE_WDT = 3;
    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [1:0] TABLE_HIGH_POINTER_RST = 2'h0;
    localparam logic [PC_W-1:0] PC_RST = 10'h000;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] FILE_RST = 8'h00;

    typedef enum logic [2:0] {
        MIE_OP_NOP = 3'h0,
        MIE_OP_BIT_TEST_SKIP_IF_SET = 3'h1,
        MIE_OP_ACCUMULATOR_INDIRECT_CALL = 3'h2,
        MIE_OP_ACCUMULATOR_CLEAR = 3'h3,
        MIE_OP_WATCHDOG_CLEAR = 3'h4,
        MIE_OP_FILE_REGISTER_CLEAR = 3'h5,
        MIE_OP_FILE_REGISTER_INVERT = 3'h6
    } mie_op_e;

    typedef enum logic [1:0] {
        MIE_ST_IDLE = 2'h0,
        MIE_ST_EXEC = 2'h1,
        MIE_ST_SECOND = 2'h2,
        MIE_ST_RESP = 2'h3
    } mie_state_e;
endpackage : mie_pkg

// *** design/mie_core.sv ***
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Behaviour
// (RULE_01) Skip-if-set with bit one discards next instruction, two cycles, else one.
// (RULE_02) Skip test takes register 0..63, bit 0..7, touches no status flag.
// (RULE_03) Indirect call pushes PC plus one, takes two cycles, flags untouched.
// (RULE_04) Indirect call loads PC[9:8] from table pointer, PC[7:0] from accumulator.
// (RULE_05) Accumulator clear writes zero and sets zero flag, one cycle.
// (RULE_06) Watchdog clear zeroes counter, and prescaler only when assigned to it.
// (RULE_07) Watchdog clear sets timeout and power-down flags to one.
// (RULE_08) File clear zeroes register 0..63, sets zero flag, one cycle.
// (RULE_09) Invert complements register; destination bit picks accumulator or register.
// (RULE_10) Invert sets zero flag from result, no other flag changes.
// (RULE_11) Indirect call advances stack pointer by one after the push.
module mie_core #(
    parameter int unsigned STACK_DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic wdt_clear_o
);
    import mie_pkg::*;
    localparam int unsigned SP_W = $clog2(STACK_DEPTH);
    generate
        if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
            $error("STACK_DEPTH must be a power of two, at least 2");
        end
    endgenerate
    mie_state_e state_reg, state_next;
    logic [INSTR_W-1:0] instr_reg;
    logic [7:0] acc_reg;
    logic [1:0] table_high_pointer_reg;
    logic z_reg, pd_n_reg, to_n_reg, pre_wdt_reg;
    logic [PC_W-1:0] pc_reg;
    logic [SP_W-1:0] sp_reg;
    logic [PC_W-1:0] stack_reg [STACK_DEPTH];
    logic [7:0] file_reg [FILE_DEPTH];
    logic [FA_W-1:0] faddr_reg;
    logic [7:0] wdt_reg, presc_reg;
    logic [31:0] rdata_reg, rd_mux, wmask, wr_word;
    logic wait_reg, wdt_clr_reg;
    mie_op_e op;
    logic [FA_W-1:0] fa;
    logic [BIT_W-1:0] bsel;
    logic dest, bit_set, exec, in_idle;
    logic [7:0] operand, inv;
    assign op = mie_op_e'(instr_reg[OP_LSB +: OP_W]);
    assign fa = instr_reg[FA_LSB +: FA_W];
    assign bsel = instr_reg[BIT_LSB +: BIT_W];
    assign dest = instr_reg[DEST_POS];
    assign operand = file_reg[fa];
    assign bit_set = operand[bsel];
    assign inv = ~operand;
    assign exec = (state_reg == MIE_ST_EXEC);
    assign in_idle = (state_reg == MIE_ST_IDLE);
    assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // Merge through the read mux, which already shows the addressed register
    assign wr_word = (rd_mux & ~wmask) | (avs_writedata_i & wmask);
    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = in_idle && avs_write_i && (avs_address_i == off);
    endfunction : wr_hit
    // Bus sequencing; an instruction write holds waitrequest until it has executed
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            MIE_ST_IDLE: begin
                if (wr_hit(OFF_INSTR)) begin
                    state_next = MIE_ST_EXEC;
                end else if (avs_read_i || avs_write_i) begin
                    state_next = MIE_ST_RESP;
                end
            end
            MIE_ST_EXEC: begin
                if ((op == MIE_OP_BIT_TEST_SKIP_IF_SET && bit_set) || // RULE_01
                    op == MIE_OP_ACCUMULATOR_INDIRECT_CALL) begin // RULE_03
                    state_next = MIE_ST_SECOND;
                end else begin
                    state_next = MIE_ST_RESP;
                end
            end
            MIE_ST_SECOND: state_next = MIE_ST_RESP;
            MIE_ST_RESP: state_next = MIE_ST_IDLE;
            default: state_next = MIE_ST_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= MIE_ST_IDLE;
            wait_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            wait_reg <= (state_next != MIE_ST_RESP);
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            instr_reg <= '0;
        end else if (wr_hit(OFF_INSTR)) begin
            instr_reg <= wr_word[INSTR_W-1:0];
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_reg <= ACC_RST;
        end else if (wr_hit(OFF_ACC)) begin
            acc_reg <= wr_word[7:0];
        end else if (exec && op == MIE_OP_ACCUMULATOR_CLEAR) begin
            acc_reg <= 8'h00; // RULE_05
        end else if (exec && op == MIE_OP_FILE_REGISTER_INVERT && !dest) begin
            acc_reg <= inv; // RULE_09
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            table_high_pointer_reg <= TABLE_HIGH_POINTER_RST;
            faddr_reg <= '0;
        end else begin
            if (wr_hit(OFF_TABLE_HIGH_POINTER)) begin
                table_high_pointer_reg <= wr_word[1:0];
            end
            if (wr_hit(OFF_FADDR)) begin
                faddr_reg <= wr_word[FA_W-1:0];
            end
        end
    end
    // Status flags; the skip test and the call leave them alone
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            z_reg <= 1'b0;
            pd_n_reg <= 1'b1;
            to_n_reg <= 1'b1;
            pre_wdt_reg <= 1'b0;
        end else if (wr_hit(OFF_STATUS)) begin
            {pre_wdt_reg, to_n_reg, pd_n_reg, z_reg} <= wr_word[ST_PRE_WDT:ST_Z];
        end else if (exec) begin
            case (op)
                MIE_OP_ACCUMULATOR_CLEAR: z_reg <= 1'b1; // RULE_05
                MIE_OP_FILE_REGISTER_CLEAR: z_reg <= 1'b1; // RULE_08
                MIE_OP_FILE_REGISTER_INVERT: z_reg <= (inv == 8'h00); // RULE_10
                MIE_OP_WATCHDOG_CLEAR: begin
                    to_n_reg <= 1'b1; // RULE_07
                    pd_n_reg <= 1'b1; // RULE_07
                end
                default: z_reg <= z_reg; // RULE_02
            endcase
        end
    end
    // Program counter; a skip spends its second cycle as a no-operation
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_reg <= PC_RST;
        end else if (wr_hit(OFF_PC)) begin
            pc_reg <= wr_word[PC_W-1:0];
        end else if (exec && op != MIE_OP_ACCUMULATOR_INDIRECT_CALL) begin
            pc_reg <= pc_reg + 10'h001;
        end else if (state_reg == MIE_ST_SECOND) begin
            if (op == MIE_OP_ACCUMULATOR_INDIRECT_CALL) begin
                pc_reg <= {table_high_pointer_reg, acc_reg}; // RULE_04
            end else begin
                pc_reg <= pc_reg + 10'h001; // RULE_01
            end
        end
    end
    // Stack wraps silently when full, like a small hardware return stack
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sp_reg <= '0;
        end else if (exec && op == MIE_OP_ACCUMULATOR_INDIRECT_CALL) begin
            sp_reg <= sp_reg + 1'b1; // RULE_11
        end
    end
    generate
        for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
            always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    stack_reg[i] <= PC_RST;
                end else if (exec && op == MIE_OP_ACCUMULATOR_INDIRECT_CALL &&
                             sp_reg == SP_W'(i)) begin
                    stack_reg[i] <= pc_reg + 10'h001; // RULE_03
                end
            end
        end
        for (genvar j = 0; j < FILE_DEPTH; j++) begin : g_file
            always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    file_reg[j] <= FILE_RST;
                end else if (wr_hit(OFF_FDATA) && faddr_reg == FA_W'(j)) begin
                    file_reg[j] <= wr_word[7:0];
                end else if (exec && fa == FA_W'(j)) begin
                    if (op == MIE_OP_FILE_REGISTER_CLEAR) begin
                        file_reg[j] <= 8'h00; // RULE_08
                    end else if (op == MIE_OP_FILE_REGISTER_INVERT && dest) begin
                        file_reg[j] <= inv; // RULE_09
                    end
                end
            end
        end
    endgenerate
    // Watchdog stand-in: prescaled when assigned, else counts every clock
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            presc_reg <= CNT_RST;
            wdt_reg <= CNT_RST;
            wdt_clr_reg <= 1'b0;
        end else begin
            wdt_clr_reg <= exec && op == MIE_OP_WATCHDOG_CLEAR;
            if (exec && op == MIE_OP_WATCHDOG_CLEAR && pre_wdt_reg) begin
                presc_reg <= CNT_RST; // RULE_06
            end else begin
                presc_reg <= presc_reg + 8'h01;
            end
            if (exec && op == MIE_OP_WATCHDOG_CLEAR) begin
                wdt_reg <= CNT_RST; // RULE_06
            end else if (!pre_wdt_reg || presc_reg == CNT_MAX) begin
                wdt_reg <= wdt_reg + 8'h01;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        case (avs_address_i)
            OFF_INSTR: rd_mux = {{(32-INSTR_W){1'b0}}, instr_reg};
            OFF_ACC: rd_mux = {24'h0, acc_reg};
            OFF_TABLE_HIGH_POINTER: rd_mux = {30'h0, table_high_pointer_reg};
            OFF_STATUS: rd_mux = {28'h0, pre_wdt_reg, to_n_reg, pd_n_reg, z_reg};
            OFF_PC: rd_mux = {22'h0, pc_reg};
            OFF_SP: rd_mux = {{(32-SP_W){1'b0}}, sp_reg};
            OFF_WDT: rd_mux = {24'h0, wdt_reg};
            OFF_PRESC: rd_mux = {24'h0, presc_reg};
            OFF_FADDR: rd_mux = {26'h0, faddr_reg};
            OFF_FDATA: rd_mux = {24'h0, file_reg[faddr_reg]};
            OFF_STKTOP: rd_mux = {22'h0, stack_reg[sp_reg - 1'b1]};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_reg <= 32'h0;
        end else if (in_idle && avs_read_i) begin
            rdata_reg <= rd_mux;
        end
    end
    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign wdt_clear_o = wdt_clr_reg;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    skip_two_cycle_a: assert property (exec && op == MIE_OP_BIT_TEST_SKIP_IF_SET && bit_set
        |=> state_reg == MIE_ST_SECOND ##1 pc_reg == $past(pc_reg, 2) + 10'h002) // RULE_01
        else $error("skip did not take two cycles");
    noskip_one_a: assert property (exec && op == MIE_OP_BIT_TEST_SKIP_IF_SET && !bit_set
        |=> state_reg == MIE_ST_RESP && pc_reg == $past(pc_reg) + 10'h001) // RULE_01
        else $error("no-skip path wrong");
    skip_flags_a: assert property (exec && op == MIE_OP_BIT_TEST_SKIP_IF_SET
        |=> $stable(z_reg) && $stable(to_n_reg) && $stable(pd_n_reg)) // RULE_02
        else $error("skip test changed a flag");
    call_push_a: assert property (exec && op == MIE_OP_ACCUMULATOR_INDIRECT_CALL
        |=> stack_reg[$past(sp_reg)] == $past(pc_reg) + 10'h001
            && sp_reg == $past(sp_reg) + 1'b1) // RULE_11
        else $error("call push or pointer wrong");
    call_target_a: assert property (exec && op == MIE_OP_ACCUMULATOR_INDIRECT_CALL
        |=> ##1 pc_reg == {$past(table_high_pointer_reg, 2), $past(acc_reg, 2)} && $stable(z_reg)) // RULE_04
        else $error("call target wrong");
    acc_clear_a: assert property (exec && op == MIE_OP_ACCUMULATOR_CLEAR
        |=> acc_reg == 8'h00 && z_reg && !avs_waitrequest_o) // RULE_05
        else $error("accumulator clear wrong");
    wdt_clear_a: assert property (exec && op == MIE_OP_WATCHDOG_CLEAR
        |=> wdt_reg == 8'h00 && to_n_reg && pd_n_reg && wdt_clear_o) // RULE_07
        else $error("watchdog clear wrong");
    presc_clear_a: assert property (exec && op == MIE_OP_WATCHDOG_CLEAR
        |=> (presc_reg == 8'h00) == $past(pre_wdt_reg)
            || $past(presc_reg) == CNT_MAX) // RULE_06
        else $error("prescaler clear wrong");
    file_clear_a: assert property (exec && op == MIE_OP_FILE_REGISTER_CLEAR
        |=> file_reg[$past(fa)] == 8'h00 && z_reg) // RULE_08
        else $error("file clear wrong");
    invert_reg_a: assert property (exec && op == MIE_OP_FILE_REGISTER_INVERT && dest
        |=> file_reg[$past(fa)] == ~$past(operand) && $stable(acc_reg)) // RULE_09
        else $error("invert to register wrong");
    invert_acc_a: assert property (exec && op == MIE_OP_FILE_REGISTER_INVERT && !dest
        |=> acc_reg == ~$past(operand) && z_reg == ($past(operand) == 8'hFF)) // RULE_10
        else $error("invert to accumulator wrong");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    skip_taken_c: cover property (exec && op == MIE_OP_BIT_TEST_SKIP_IF_SET && bit_set);
    call_done_c: cover property (state_reg == MIE_ST_SECOND
        && op == MIE_OP_ACCUMULATOR_INDIRECT_CALL);
    wdt_clr_c: cover property (wdt_clear_o && pre_wdt_reg);
    invert_c: cover property (exec && op == MIE_OP_FILE_REGISTER_INVERT && dest);
endmodule : mie_core

// *** verif/mie_prog_mem.sv ***
`timescale 1ns/100ps
// Program store holding the fetched words; the bench copies each one into the core
module mie_prog_mem (
    input wire logic [3:0] pm_addr_i,
    output logic [12:0] pm_word_o
);
    always_comb begin
        case (pm_addr_i)
            4'h1: pm_word_o = 13'h0FF9;
            4'h2: pm_word_o = 13'h0629;
            4'h3: pm_word_o = 13'h0002;
            4'h4: pm_word_o = 13'h0003;
            4'h5: pm_word_o = 13'h0004;
            4'h6: pm_word_o = 13'h01FD;
            4'h7: pm_word_o = 13'h1056;
            4'h8: pm_word_o = 13'h0056;
            4'h9: pm_word_o = 13'h0007;
            default: pm_word_o = 13'h0000;
        endcase
    end
endmodule : mie_prog_mem

// *** verif/tb.sv ***
`timescale 1ns/100ps
module tb;
    import mie_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic wait_q;
    logic wdt_clr;
    logic [3:0] pm_addr = 4'h0;
    logic [12:0] pm_word;
    int failures = 0;
    int check_count = 0;
    int pulses = 0;
    mie_core DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
        .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_q),
        .wdt_clear_o(wdt_clr));
    mie_prog_mem PM (.pm_addr_i(pm_addr), .pm_word_o(pm_word));
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (wdt_clr === 1'b1) pulses <= pulses + 1;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Request held until waitrequest is sampled low; n counts edges from the take
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q, output int n);
        adr <= a;
        wdata <= d;
        wr_q <= w;
        rd_q <= !w;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wait_q !== 1'b0);
        q = rdata;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
        @(posedge sys_clk_i);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        int n;
        bus(a, 1'b1, d, q, n);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        int n;
        bus(a, 1'b0, 32'h0, q, n);
    endtask : rd
    task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        rd(a, q);
        check(nm, q, exp);
    endtask : chk
    // Word from the program store is copied into the instruction register
    task automatic run(input logic [3:0] i, output int n);
        logic [31:0] q;
        pm_addr <= i;
        @(posedge sys_clk_i);
        bus(OFF_INSTR, 1'b1, {19'h0, pm_word}, q, n);
    endtask : run
    task automatic t_reset();
        int n;
        chk("acc", OFF_ACC, 32'h0);
        chk("status", OFF_STATUS, 32'h06);
        chk("pc", OFF_PC, 32'h0);
        chk("sp", OFF_SP, 32'h0);
        wr(OFF_SP, 32'h5);
        chk("sp_ro", OFF_SP, 32'h0);
        chk("unmapped", 8'h3C, 32'h0);
        // Only enabled byte lanes may land
        be <= 4'h1;
        wr(OFF_ACC, 32'hFFFFFF77);
        be <= 4'hE;
        wr(OFF_ACC, 32'h00000000);
        chk("acc_lanes", OFF_ACC, 32'h77);
        be <= 4'hF;
        wr(OFF_PC, 32'h100);
        run(4'h0, n);
        chk("pc_nop", OFF_PC, 32'h101);
        run(4'h9, n);
        chk("pc_op7", OFF_PC, 32'h102);
    endtask : t_reset
    task automatic t_skip();
        int n;
        wr(OFF_FADDR, 32'd63);
        wr(OFF_FDATA, 32'h7F);
        wr(OFF_FADDR, 32'd5);
        wr(OFF_FDATA, 32'h08);
        wr(OFF_STATUS, 32'h05);
        wr(OFF_PC, 32'h010);
        run(4'h1, n);
        check("skip_no_cyc", n, 3);
        chk("skip_no_pc", OFF_PC, 32'h011);
        run(4'h2, n);
        check("skip_cyc", n, 4);
        chk("skip_pc", OFF_PC, 32'h013);
        chk("skip_st", OFF_STATUS, 32'h05);
        chk("skip_reg", OFF_FDATA, 32'h08);
    endtask : t_skip
    task automatic t_call();
        int n;
        logic [31:0] sp0;
        rd(OFF_SP, sp0);
        wr(OFF_TABLE_HIGH_POINTER, 32'h02);
        wr(OFF_ACC, 32'h34);
        wr(OFF_PC, 32'h0A0);
        wr(OFF_STATUS, 32'h02);
        run(4'h3, n);
        check("call_cyc", n, 4);
        chk("call_pc", OFF_PC, 32'h234);
        chk("call_top", OFF_STKTOP, 32'h0A1);
        chk("call_sp", OFF_SP, sp0 + 1);
        chk("call_st", OFF_STATUS, 32'h02);
        wr(OFF_TABLE_HIGH_POINTER, 32'hFF);
        wr(OFF_ACC, 32'hFF);
        run(4'h3, n);
        chk("call_pc2", OFF_PC, 32'h3FF);
        chk("call_top2", OFF_STKTOP, 32'h235);
        chk("call_sp2", OFF_SP, sp0 + 2);
    endtask : t_call
    task automatic t_accclr();
        int n;
        wr(OFF_ACC, 32'h55);
        wr(OFF_STATUS, 32'h06);
        run(4'h4, n);
        check("aclr_cyc", n, 3);
        chk("aclr_acc", OFF_ACC, 32'h0);
        chk("aclr_st", OFF_STATUS, 32'h07);
    endtask : t_accclr
    // Counters free-run, so only bounds are checked where cycles pass before the read
    task automatic t_wdt();
        int n;
        int p;
        logic [31:0] q;
        wr(OFF_STATUS, 32'h08);
        p = pulses;
        run(4'h5, n);
        check("wclr_cyc", n, 3);
        check("wclr_pulse", pulses, p + 1);
        chk("wclr_st", OFF_STATUS, 32'h0E);
        chk("wclr_wdt", OFF_WDT, 32'h0);
        rd(OFF_PRESC, q);
        check("presc_clr", {31'h0, q < 32'd16}, 32'h1);
        repeat (100) @(posedge sys_clk_i);
        wr(OFF_STATUS, 32'h00);
        run(4'h5, n);
        chk("wclr_st2", OFF_STATUS, 32'h06);
        rd(OFF_WDT, q);
        check("wdt_clr2", {31'h0, q < 32'd16}, 32'h1);
        rd(OFF_PRESC, q);
        check("presc_kept", {31'h0, q >= 32'd100}, 32'h1);
    endtask : t_wdt
    task automatic t_fclr();
        int n;
        wr(OFF_FADDR, 32'd63);
        wr(OFF_FDATA, 32'h55);
        wr(OFF_STATUS, 32'h06);
        run(4'h6, n);
        check("fclr_cyc", n, 3);
        chk("fclr_reg", OFF_FDATA, 32'h0);
        chk("fclr_st", OFF_STATUS, 32'h07);
    endtask : t_fclr
    task automatic t_invert();
        int n;
        wr(OFF_FADDR, 32'd10);
        wr(OFF_FDATA, 32'hA6);
        wr(OFF_ACC, 32'h11);
        wr(OFF_STATUS, 32'h07);
        run(4'h7, n);
        check("inv_cyc", n, 3);
        chk("inv_reg", OFF_FDATA, 32'h59);
        chk("inv_acc", OFF_ACC, 32'h11);
        chk("inv_st", OFF_STATUS, 32'h06);
        wr(OFF_FDATA, 32'hFF);
        run(4'h8, n);
        chk("inv_acc2", OFF_ACC, 32'h0);
        chk("inv_reg2", OFF_FDATA, 32'hFF);
        chk("inv_st2", OFF_STATUS, 32'h07);
    endtask : t_invert
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    // Whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        @(posedge sys_clk_i);
        t_reset();
        t_skip();
        t_call();
        t_accclr();
        t_wdt();
        t_fclr();
        t_invert();
        wrap_up();
    end
endmodule : tb
